// [core/sfrfm_top.sv]
// system special function register bank with address map and flash guard
`timescale 1ns/1ps
`include "sfrfm_cfg.svh"
module sfrfm_top (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic power_up_clear_in,
   input wire sfrfm_pkg::sfrfm_bus_req_t bus_in,
   output logic [15:0] bus_rdata_out,
   output sfrfm_pkg::sfrfm_region_t bus_region_out,
   input wire logic watchdog_overflow_in,
   input wire logic watchdog_interval_mode_in,
   input wire logic osc_fault_in,
   input wire logic nmi_pin_event_in,
   input wire logic ext_reset_event_in,
   input wire logic flash_violation_flag_in,
   input wire logic seg_a_unlock_in,
   input wire logic seg_a_lock_in,
   input wire sfrfm_pkg::sfrfm_flash_req_t flash_req_in,
   output sfrfm_pkg::sfrfm_flash_cmd_t flash_cmd_out,
   output logic seg_a_locked_out,
   output logic flash_violation_irq_en_out,
   output logic nonmaskable_irq_en_out,
   output logic osc_fault_irq_en_out,
   output logic watchdog_interval_irq_en_out,
   output logic osc_fault_flag_out,
   output logic nmi_req_out,
   output logic watchdog_irq_out
);
   logic [7:0] enable_q;
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic wr_ie1;
   logic wr_system_interrupt_flags_1;
   logic [7:0] wr_byte_ie1;
   logic [7:0] wr_byte_system_interrupt_flags_1;
   sfrfm_pkg::sfrfm_flash_cmd_t guard_cmd;
   logic guard_locked;

   // word address must match and the byte's own strobe be set, so a reserved neighbour byte never leaks in
   function automatic logic lane_hit(input sfrfm_pkg::sfrfm_bus_req_t r, input logic [15:0] a);
      lane_hit = r.wr && (r.addr[15:1] == a[15:1]) && r.be[a[0]];
   endfunction : lane_hit

   function automatic logic [7:0] lane_data(input sfrfm_pkg::sfrfm_bus_req_t r, input logic [15:0] a);
      lane_data = (a[0] && r.be[1]) ? r.wdata[15:8] : r.wdata[7:0];
   endfunction : lane_data

   // register read value for one byte address; absent bits read zero
   function automatic logic [7:0] read_byte(input logic [15:0] a, input logic [7:0] ie, input logic [7:0] fl);
      unique case (a)
         `SFRFM_ADDR_IE1: read_byte = ie & `SFRFM_IE1_MASK;
         `SFRFM_ADDR_SYSTEM_INTERRUPT_FLAGS_1: read_byte = fl & `SFRFM_SYSTEM_INTERRUPT_FLAGS_1_MASK;
         default: read_byte = 8'h00;
      endcase
   endfunction : read_byte

   assign wr_ie1 = lane_hit(bus_in, `SFRFM_ADDR_IE1);
   assign wr_system_interrupt_flags_1 = lane_hit(bus_in, `SFRFM_ADDR_SYSTEM_INTERRUPT_FLAGS_1);
   assign wr_byte_ie1 = lane_data(bus_in, `SFRFM_ADDR_IE1);
   assign wr_byte_system_interrupt_flags_1 = lane_data(bus_in, `SFRFM_ADDR_SYSTEM_INTERRUPT_FLAGS_1);

   // enable byte: all present bits cleared by power-up clear
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         enable_q <= `SFRFM_IE1_RESET;
      else if (power_up_clear_in)
         enable_q <= `SFRFM_IE1_RESET;
      else if (wr_ie1)
         enable_q <= wr_byte_ie1 & `SFRFM_IE1_MASK;
   end

   // hardware events win over a software clear in the same cycle
   always_comb
   begin
      flags_d = wr_system_interrupt_flags_1 ? (wr_byte_system_interrupt_flags_1 & `SFRFM_SYSTEM_INTERRUPT_FLAGS_1_MASK) : flags_q;
      flags_d[`SFRFM_BIT_WDTFLAG] = flags_d[`SFRFM_BIT_WDTFLAG] | watchdog_overflow_in;
      flags_d[`SFRFM_BIT_OFFLAG] = flags_d[`SFRFM_BIT_OFFLAG] | osc_fault_in;
      flags_d[`SFRFM_BIT_RSTFLAG] = flags_d[`SFRFM_BIT_RSTFLAG] | ext_reset_event_in;
      flags_d[`SFRFM_BIT_NMIFLAG] = flags_d[`SFRFM_BIT_NMIFLAG] | nmi_pin_event_in;
      if (power_up_clear_in)
      begin
         // only the clear-initialised bits move; the power-on bits hold
         flags_d[`SFRFM_BIT_OFFLAG] = 1'b1;
         flags_d[`SFRFM_BIT_NMIFLAG] = 1'b0;
         flags_d[`SFRFM_BIT_WDTFLAG] = flags_q[`SFRFM_BIT_WDTFLAG] | watchdog_overflow_in;
         flags_d[`SFRFM_BIT_PORFLAG] = flags_q[`SFRFM_BIT_PORFLAG];
         flags_d[`SFRFM_BIT_RSTFLAG] = flags_q[`SFRFM_BIT_RSTFLAG] | ext_reset_event_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         flags_q <= `SFRFM_SYSTEM_INTERRUPT_FLAGS_1_POR;
      else
         flags_q <= flags_d;
   end

   // read data and region registered: one cycle after the request
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         bus_rdata_out <= 16'h0000;
         bus_region_out <= sfrfm_pkg::SFRFM_REG_NONE;
      end
      else
      begin
         bus_region_out <= sfrfm_pkg::sfrfm_decode(bus_in.addr);
         if (bus_in.rd)
            bus_rdata_out <= {read_byte({bus_in.addr[15:1], 1'b1}, enable_q, flags_q),
                              read_byte({bus_in.addr[15:1], 1'b0}, enable_q, flags_q)};
      end
   end

   // shared nonmaskable request and the interval-mode watchdog request
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         nmi_req_out <= 1'b0;
         watchdog_irq_out <= 1'b0;
      end
      else
      begin
         nmi_req_out <= (flash_violation_flag_in && enable_q[`SFRFM_BIT_FLASH_VIOLATION_IRQ_EN]) ||
                        (flags_q[`SFRFM_BIT_OFFLAG] && enable_q[`SFRFM_BIT_OSC_FAULT_IRQ_EN]) ||
                        (flags_q[`SFRFM_BIT_NMIFLAG] && enable_q[`SFRFM_BIT_NONMASKABLE_IRQ_EN]);
         watchdog_irq_out <= watchdog_interval_mode_in && flags_q[`SFRFM_BIT_WDTFLAG] &&
                             enable_q[`SFRFM_BIT_WATCHDOG_INTERVAL_IRQ_EN];
      end
   end

   sfrfm_flash_guard u_guard (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .power_up_clear_in(power_up_clear_in),
      .seg_a_unlock_in(seg_a_unlock_in),
      .seg_a_lock_in(seg_a_lock_in),
      .req_in(flash_req_in),
      .cmd_out(guard_cmd),
      .seg_a_locked_out(guard_locked)
   );

   assign flash_cmd_out = guard_cmd;
   assign seg_a_locked_out = guard_locked;
   assign flash_violation_irq_en_out = enable_q[`SFRFM_BIT_FLASH_VIOLATION_IRQ_EN];
   assign nonmaskable_irq_en_out = enable_q[`SFRFM_BIT_NONMASKABLE_IRQ_EN];
   assign osc_fault_irq_en_out = enable_q[`SFRFM_BIT_OSC_FAULT_IRQ_EN];
   assign watchdog_interval_irq_en_out = enable_q[`SFRFM_BIT_WATCHDOG_INTERVAL_IRQ_EN];
   assign osc_fault_flag_out = flags_q[`SFRFM_BIT_OFFLAG];
endmodule : sfrfm_top

// [core/sfrfm_cfg.svh]
// constants of the special function register bank and flash map
// Operation
// - enable and module bits live in byte region 00h to 0Fh at address bottom.
// - unassigned register bits have no storage, read zero, ignore writes.
// - bits cleared or set by power-up clear are forced then, read/write otherwise.
// - bits initialised by power-on reset keep their contents across power-up clear.
// - enable byte 0: bit5 flash violation, bit4 nmi, bit1 osc fault, bit0 watchdog.
// - watchdog enable gates watchdog request only in interval timer mode.
// - flash takes cpu byte or word writes, and writes from the debug port.
// - information flash has four 64-byte segments A to D.
// - main flash erases in uniform 512-byte segments.
// - main flash erases all segments at once or one segment alone.
// - each info segment erases alone, or all together with main segments; a locked segment A is left out of the combined erase.
// - after any reset, segment A is locked until software unlocks it.
// - flash violation, osc fault or nmi flag raises nmi request when enabled.
`ifndef SFRFM_CFG_SVH
`define SFRFM_CFG_SVH
`define SFRFM_ADDR_IE1 16'h0000
`define SFRFM_ADDR_IE2 16'h0001
`define SFRFM_ADDR_SYSTEM_INTERRUPT_FLAGS_1 16'h0002
`define SFRFM_ADDR_SYSTEM_INTERRUPT_FLAGS_2 16'h0003
`define SFRFM_BIT_WATCHDOG_INTERVAL_IRQ_EN 0
`define SFRFM_BIT_OSC_FAULT_IRQ_EN 1
`define SFRFM_BIT_NONMASKABLE_IRQ_EN 4
`define SFRFM_BIT_FLASH_VIOLATION_IRQ_EN 5
`define SFRFM_BIT_WDTFLAG 0
`define SFRFM_BIT_OFFLAG 1
`define SFRFM_BIT_PORFLAG 2
`define SFRFM_BIT_RSTFLAG 3
`define SFRFM_BIT_NMIFLAG 4
`define SFRFM_IE1_MASK 8'h33
`define SFRFM_SYSTEM_INTERRUPT_FLAGS_1_MASK 8'h1F
`define SFRFM_IE1_RESET 8'h00
`define SFRFM_SYSTEM_INTERRUPT_FLAGS_1_POR 8'h06
`define SFRFM_SFR_TOP 16'h000F
`define SFRFM_PER8_TOP 16'h00FF
`define SFRFM_PER16_TOP 16'h01FF
`define SFRFM_RAM_BASE 16'h0200
`define SFRFM_RAM_TOP 16'h02FF
`define SFRFM_INFO_BASE 16'h1000
`define SFRFM_INFO_TOP 16'h10FF
`define SFRFM_MAIN_BASE 16'hE000
`define SFRFM_VECT_BASE 16'hFFC0
`define SFRFM_INFO_SEG_A 2'h3
`define SFRFM_INFO_ALL 4'hF
`define SFRFM_INFO_NONE 4'h0
`endif

// [core/sfrfm_pkg.sv]
// types and address decode shared by the sfr bank and flash guard
`include "sfrfm_cfg.svh"
package sfrfm_pkg;
   typedef enum logic [2:0] {
      SFRFM_REG_SFR = 3'b000,
      SFRFM_REG_PER8 = 3'b001,
      SFRFM_REG_PER16 = 3'b010,
      SFRFM_REG_RAM = 3'b011,
      SFRFM_REG_INFO = 3'b100,
      SFRFM_REG_MAIN = 3'b101,
      SFRFM_REG_VECT = 3'b110,
      SFRFM_REG_NONE = 3'b111
   } sfrfm_region_t;

   typedef enum logic [2:0] {
      SFRFM_OP_IDLE = 3'b000,
      SFRFM_OP_PROG_BYTE = 3'b001,
      SFRFM_OP_PROG_WORD = 3'b010,
      SFRFM_OP_ERASE_SEG = 3'b011,
      SFRFM_OP_ERASE_MAIN = 3'b100,
      SFRFM_OP_ERASE_ALL = 3'b101
   } sfrfm_op_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [1:0] be;
      logic wr;
      logic rd;
   } sfrfm_bus_req_t;

   typedef struct packed {
      logic valid;
      sfrfm_op_t op;
      logic [15:0] addr;
      logic from_debug;
   } sfrfm_flash_req_t;

   typedef struct packed {
      logic go;
      logic reject;
      sfrfm_op_t op;
      logic [15:0] addr;
      logic erase_main_all;
      logic [6:0] main_seg;
      logic [3:0] info_mask;
   } sfrfm_flash_cmd_t;

   // region of a cpu address; vectors are tested before main code since they overlap it
   function automatic sfrfm_region_t sfrfm_decode(input logic [15:0] a);
      if (a <= `SFRFM_SFR_TOP)
         sfrfm_decode = SFRFM_REG_SFR;
      else if (a <= `SFRFM_PER8_TOP)
         sfrfm_decode = SFRFM_REG_PER8;
      else if (a <= `SFRFM_PER16_TOP)
         sfrfm_decode = SFRFM_REG_PER16;
      else if (a >= `SFRFM_RAM_BASE && a <= `SFRFM_RAM_TOP)
         sfrfm_decode = SFRFM_REG_RAM;
      else if (a >= `SFRFM_INFO_BASE && a <= `SFRFM_INFO_TOP)
         sfrfm_decode = SFRFM_REG_INFO;
      else if (a >= `SFRFM_VECT_BASE)
         sfrfm_decode = SFRFM_REG_VECT;
      else if (a >= `SFRFM_MAIN_BASE)
         sfrfm_decode = SFRFM_REG_MAIN;
      else
         sfrfm_decode = SFRFM_REG_NONE;
   endfunction : sfrfm_decode
endpackage : sfrfm_pkg

// [core/sfrfm_flash_guard.sv]
// flash request screening: segment lock, segment selection, erase scope
`timescale 1ns/1ps
`include "sfrfm_cfg.svh"
module sfrfm_flash_guard (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic power_up_clear_in,
   input wire logic seg_a_unlock_in,
   input wire logic seg_a_lock_in,
   input wire sfrfm_pkg::sfrfm_flash_req_t req_in,
   output sfrfm_pkg::sfrfm_flash_cmd_t cmd_out,
   output logic seg_a_locked_out
);
   logic lock_q;
   logic [3:0] info_mask_d;
   logic allowed_d;
   logic is_info;
   logic is_main;
   logic is_seg_a;

   assign is_info = (sfrfm_pkg::sfrfm_decode(req_in.addr) == sfrfm_pkg::SFRFM_REG_INFO);
   assign is_main = (sfrfm_pkg::sfrfm_decode(req_in.addr) == sfrfm_pkg::SFRFM_REG_MAIN) ||
                    (sfrfm_pkg::sfrfm_decode(req_in.addr) == sfrfm_pkg::SFRFM_REG_VECT);
   assign is_seg_a = is_info && (req_in.addr[7:6] == `SFRFM_INFO_SEG_A);

   // any reset relocks; a lock request in the same cycle as unlock wins
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         lock_q <= 1'b1;
      else if (power_up_clear_in || seg_a_lock_in)
         lock_q <= 1'b1;
      else if (seg_a_unlock_in)
         lock_q <= 1'b0;
   end

   always_comb
   begin
      info_mask_d = `SFRFM_INFO_NONE;
      allowed_d = 1'b0;
      unique case (req_in.op)
         sfrfm_pkg::SFRFM_OP_IDLE:
            allowed_d = 1'b0;
         sfrfm_pkg::SFRFM_OP_PROG_BYTE,
         sfrfm_pkg::SFRFM_OP_PROG_WORD:
            // word writes need an even address; both sources accepted
            allowed_d = (is_main || is_info) && !(is_seg_a && lock_q) &&
                        !(req_in.op == sfrfm_pkg::SFRFM_OP_PROG_WORD && req_in.addr[0]);
         sfrfm_pkg::SFRFM_OP_ERASE_SEG:
         begin
            allowed_d = is_main || (is_info && !(is_seg_a && lock_q));
            if (is_info)
               info_mask_d = 4'(4'h1 << req_in.addr[7:6]);
         end
         sfrfm_pkg::SFRFM_OP_ERASE_MAIN:
            allowed_d = 1'b1;
         sfrfm_pkg::SFRFM_OP_ERASE_ALL:
         begin
            // a locked segment A is left out of the combined erase
            allowed_d = 1'b1;
            info_mask_d = lock_q ? 4'h7 : `SFRFM_INFO_ALL;
         end
         default:
            allowed_d = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         cmd_out <= '0;
      else
      begin
         cmd_out.go <= req_in.valid && allowed_d;
         cmd_out.reject <= req_in.valid && !allowed_d;
         cmd_out.op <= req_in.op;
         cmd_out.addr <= req_in.addr;
         cmd_out.erase_main_all <= req_in.valid && allowed_d &&
                                   (req_in.op == sfrfm_pkg::SFRFM_OP_ERASE_MAIN ||
                                    req_in.op == sfrfm_pkg::SFRFM_OP_ERASE_ALL);
         cmd_out.main_seg <= req_in.addr[15:9];
         cmd_out.info_mask <= (req_in.valid && allowed_d) ? info_mask_d : `SFRFM_INFO_NONE;
      end
   end

   assign seg_a_locked_out = lock_q;
endmodule : sfrfm_flash_guard

// [bench/sfrfm_assertions.sv]
// concurrent checks on the ports of the sfr bank and flash guard
`timescale 1ns/1ps
module sfrfm_assertions (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic power_up_clear_in,
   input wire sfrfm_pkg::sfrfm_bus_req_t bus_in,
   input wire logic [15:0] bus_rdata_out,
   input wire logic watchdog_interval_mode_in,
   input wire logic osc_fault_in,
   input wire logic seg_a_unlock_in,
   input wire sfrfm_pkg::sfrfm_flash_req_t flash_req_in,
   input wire sfrfm_pkg::sfrfm_flash_cmd_t flash_cmd_out,
   input wire logic seg_a_locked_out,
   input wire logic flash_violation_irq_en_out,
   input wire logic nonmaskable_irq_en_out,
   input wire logic osc_fault_irq_en_out,
   input wire logic watchdog_interval_irq_en_out,
   input wire logic osc_fault_flag_out,
   input wire logic nmi_req_out,
   input wire logic watchdog_irq_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic any_en;
   assign any_en = flash_violation_irq_en_out | nonmaskable_irq_en_out | osc_fault_irq_en_out;
   pup_forces_a: assert property (power_up_clear_in |=> !any_en && !watchdog_interval_irq_en_out
      && osc_fault_flag_out && seg_a_locked_out) else $error("power-up clear left a bit unforced");
   ie_write_a: assert property (bus_in.wr && bus_in.addr == 16'h0000 && bus_in.be[0] && !power_up_clear_in
      |=> {flash_violation_irq_en_out, nonmaskable_irq_en_out} == $past(bus_in.wdata[5:4])) else $error("enable write lost");
   ie_empty_a: assert property (bus_in.rd && bus_in.addr == 16'h0000
      |=> bus_rdata_out[15:6] == 10'h000 && bus_rdata_out[3:2] == 2'h0) else $error("absent enable bit reads one");
   ifg_empty_a: assert property (bus_in.rd && bus_in.addr == 16'h0002
      |=> bus_rdata_out[15:5] == 11'h000) else $error("absent flag bit reads one");
   osc_set_a: assert property (osc_fault_in |=> osc_fault_flag_out) else $error("fault flag not set");
   nmi_cause_a: assert property (nmi_req_out |-> $past(any_en)) else $error("nmi without enable");
   nmi_osc_a: assert property (osc_fault_flag_out && osc_fault_irq_en_out && !power_up_clear_in
      |=> nmi_req_out) else $error("enabled fault gave no nmi");
   wdt_gate_a: assert property (!watchdog_interval_mode_in |=> !watchdog_irq_out) else $error("wdt irq in reset mode");
   answer_src_a: assert property (flash_cmd_out.go || flash_cmd_out.reject
      |-> $past(flash_req_in.valid) && !(flash_cmd_out.go && flash_cmd_out.reject)) else $error("stray flash answer");
   seg_a_lock_a: assert property (flash_req_in.valid && flash_req_in.op == sfrfm_pkg::SFRFM_OP_PROG_BYTE
      && flash_req_in.addr[15:6] == 10'h043 && seg_a_locked_out && !seg_a_unlock_in
      |=> flash_cmd_out.reject) else $error("locked segment programmed");
   erase_all_a: assert property (flash_req_in.valid && flash_req_in.op == sfrfm_pkg::SFRFM_OP_ERASE_ALL
      |=> flash_cmd_out.go && flash_cmd_out.erase_main_all && flash_cmd_out.info_mask[2:0] == 3'h7)
      else $error("combined erase scope wrong");
   cover property (nmi_req_out);
   cover property (watchdog_irq_out);
   cover property (flash_cmd_out.reject);
endmodule : sfrfm_assertions
bind sfrfm_top sfrfm_assertions u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .power_up_clear_in(power_up_clear_in),
   .bus_in(bus_in), .bus_rdata_out(bus_rdata_out), .watchdog_interval_mode_in(watchdog_interval_mode_in),
   .osc_fault_in(osc_fault_in), .seg_a_unlock_in(seg_a_unlock_in), .flash_req_in(flash_req_in),
   .flash_cmd_out(flash_cmd_out), .seg_a_locked_out(seg_a_locked_out),
   .flash_violation_irq_en_out(flash_violation_irq_en_out), .nonmaskable_irq_en_out(nonmaskable_irq_en_out),
   .osc_fault_irq_en_out(osc_fault_irq_en_out), .watchdog_interval_irq_en_out(watchdog_interval_irq_en_out),
   .osc_fault_flag_out(osc_fault_flag_out), .nmi_req_out(nmi_req_out), .watchdog_irq_out(watchdog_irq_out));

// [bench/sfrfm_cpu_model.sv]
// cpu side of the peripheral bus: byte and word register cycles
`timescale 1ns/1ps
module sfrfm_cpu_model (
   input wire logic clk_in,
   input wire logic [15:0] rdata_in,
   output sfrfm_pkg::sfrfm_bus_req_t bus_out
);
   initial bus_out = '0;
   task automatic cyc(input logic [15:0] a, input logic [15:0] d, input logic [1:0] b, input logic w,
      output logic [15:0] q);
      @(posedge clk_in);
      #1 bus_out = '{addr: a, wdata: d, be: b, wr: w, rd: !w};
      @(posedge clk_in);
      #1 q = rdata_in;
      bus_out.wr = 1'b0;
      bus_out.rd = 1'b0;
      // released data lines flip so a stale value cannot pass
      bus_out.wdata = ~d;
   endtask : cyc
endmodule : sfrfm_cpu_model

// [bench/system_sfr_and_flash_map_tb_top.sv]
// self-checking bench for the sfr bank and flash guard
`timescale 1ns/1ps
module system_sfr_and_flash_map_tb_top;
   logic clk_in, rst_n_in, pup, wdt_ovf, wdt_mode, osc, nmi_ev, viol, unl, lck, locked, en_v, en_n, en_o, en_w;
   logic off, nmi, wirq, rst_ev;
   sfrfm_pkg::sfrfm_region_t region;
   logic [15:0] rdata, q;
   sfrfm_pkg::sfrfm_bus_req_t bus;
   sfrfm_pkg::sfrfm_flash_req_t freq;
   sfrfm_pkg::sfrfm_flash_cmd_t cmd;
   int n_mismatch = 0;
   int num_checks = 0;
   sfrfm_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .power_up_clear_in(pup), .bus_in(bus), .bus_rdata_out(rdata),
      .bus_region_out(region), .watchdog_overflow_in(wdt_ovf), .watchdog_interval_mode_in(wdt_mode), .osc_fault_in(osc),
      .nmi_pin_event_in(nmi_ev), .ext_reset_event_in(rst_ev), .flash_violation_flag_in(viol), .seg_a_unlock_in(unl),
      .seg_a_lock_in(lck), .flash_req_in(freq), .flash_cmd_out(cmd), .seg_a_locked_out(locked),
      .flash_violation_irq_en_out(en_v), .nonmaskable_irq_en_out(en_n), .osc_fault_irq_en_out(en_o),
      .watchdog_interval_irq_en_out(en_w), .osc_fault_flag_out(off), .nmi_req_out(nmi), .watchdog_irq_out(wirq));
   sfrfm_cpu_model cpu (.clk_in(clk_in), .rdata_in(rdata), .bus_out(bus));
   initial
   begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      cpu.cyc(a, d, 2'h3, 1'b1, q);
   endtask : wr
   task automatic rdc(input logic [15:0] a, input logic [15:0] e);
      cpu.cyc(a, 16'h0000, 2'h3, 1'b0, q);
      chk(q, e);
   endtask : rdc
   task automatic ev(ref logic s);
      @(posedge clk_in);
      #1 s = 1'b1;
      @(posedge clk_in);
      #1 s = 1'b0;
   endtask : ev
   // s picks the extra field: 1 info mask, 2 main segment, 3 whole-main flag
   task automatic fr(input sfrfm_pkg::sfrfm_op_t op, input logic [15:0] a, input logic g, input logic [7:0] e,
      input int s);
      @(posedge clk_in);
      #1 freq = '{valid: 1'b1, op: op, addr: a, from_debug: 1'b0};
      @(posedge clk_in);
      #1 freq.valid = 1'b0;
      chk(16'({cmd.go, cmd.reject}), 16'({g, !g}));
      if (s == 1)
         chk(16'(cmd.info_mask), 16'(e));
      if (s == 2)
         chk(16'(cmd.main_seg), 16'(e));
      if (s == 3)
         chk(16'(cmd.erase_main_all), 16'(e));
   endtask : fr
   task automatic t_reset;
      rdc(16'h0000, 16'h0000);
      rdc(16'h0002, 16'h0006);
      chk(16'(locked), 16'h0001);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_regs;
      wr(16'h0000, 16'hFFFF);
      cpu.cyc(16'h0001, 16'hFF00, 2'h2, 1'b1, q);
      rdc(16'h0000, 16'h0033);
      chk(16'({en_v, en_n, en_o, en_w}), 16'h000F);
      wr(16'h0002, 16'hFFFF);
      rdc(16'h0002, 16'h001F);
      wr(16'h0004, 16'hFFFF);
      rdc(16'h0004, 16'h0000);
      $display("t_regs done");
   endtask : t_regs
   task automatic rg(input logic [15:0] a, input sfrfm_pkg::sfrfm_region_t e);
      rdc(a, 16'h0000);
      chk(16'(region), 16'(e));
   endtask : rg
   task automatic t_map;
      rg(16'h000F, sfrfm_pkg::SFRFM_REG_SFR);
      rg(16'h0010, sfrfm_pkg::SFRFM_REG_PER8);
      rg(16'h01FF, sfrfm_pkg::SFRFM_REG_PER16);
      rg(16'h0200, sfrfm_pkg::SFRFM_REG_RAM);
      rg(16'h0300, sfrfm_pkg::SFRFM_REG_NONE);
      rg(16'h10FF, sfrfm_pkg::SFRFM_REG_INFO);
      rg(16'hE000, sfrfm_pkg::SFRFM_REG_MAIN);
      rg(16'hFFC0, sfrfm_pkg::SFRFM_REG_VECT);
      $display("t_map done");
   endtask : t_map
   task automatic t_nmi;
      wr(16'h0002, 16'h0000);
      rdc(16'h0002, 16'h0000);
      chk(16'(nmi), 16'h0000);
      ev(nmi_ev);
      rdc(16'h0002, 16'h0010);
      chk(16'(nmi), 16'h0001);
      wr(16'h0000, 16'h0023);
      rdc(16'h0000, 16'h0023);
      chk(16'(nmi), 16'h0000);
      ev(osc);
      rdc(16'h0002, 16'h0012);
      chk(16'(nmi), 16'h0001);
      wr(16'h0000, 16'h0020);
      wr(16'h0002, 16'h0000);
      viol = 1'b1;
      rdc(16'h0002, 16'h0000);
      chk(16'(nmi), 16'h0001);
      viol = 1'b0;
      $display("t_nmi done");
   endtask : t_nmi
   task automatic t_pup;
      wr(16'h0002, 16'h001F);
      wr(16'h0000, 16'h0033);
      ev(unl);
      ev(pup);
      rdc(16'h0000, 16'h0000);
      rdc(16'h0002, 16'h000F);
      chk(16'(locked), 16'h0001);
      $display("t_pup done");
   endtask : t_pup
   task automatic t_wdt;
      wr(16'h0002, 16'h0000);
      ev(wdt_ovf);
      ev(rst_ev);
      rdc(16'h0002, 16'h0009);
      wr(16'h0000, 16'h0001);
      rdc(16'h0000, 16'h0001);
      chk(16'(wirq), 16'h0000);
      wdt_mode = 1'b1;
      rdc(16'h0000, 16'h0001);
      chk(16'(wirq), 16'h0001);
      wdt_mode = 1'b0;
      $display("t_wdt done");
   endtask : t_wdt
   task automatic t_flash;
      fr(sfrfm_pkg::SFRFM_OP_ERASE_ALL, 16'hE000, 1'b1, 8'h07, 1);
      fr(sfrfm_pkg::SFRFM_OP_PROG_BYTE, 16'h10C0, 1'b0, 8'h00, 0);
      fr(sfrfm_pkg::SFRFM_OP_ERASE_SEG, 16'h10C2, 1'b0, 8'h00, 0);
      fr(sfrfm_pkg::SFRFM_OP_ERASE_SEG, 16'h1080, 1'b1, 8'h04, 1);
      fr(sfrfm_pkg::SFRFM_OP_ERASE_SEG, 16'hE200, 1'b1, 8'h71, 2);
      fr(sfrfm_pkg::SFRFM_OP_ERASE_MAIN, 16'hE000, 1'b1, 8'h01, 3);
      fr(sfrfm_pkg::SFRFM_OP_PROG_WORD, 16'h1001, 1'b0, 8'h00, 0);
      fr(sfrfm_pkg::SFRFM_OP_PROG_WORD, 16'hE002, 1'b1, 8'h00, 0);
      ev(unl);
      chk(16'(locked), 16'h0000);
      // unlocked segment a is only programmed, never erased, to keep calibration
      fr(sfrfm_pkg::SFRFM_OP_PROG_BYTE, 16'h10C1, 1'b1, 8'h00, 0);
      ev(lck);
      chk(16'(locked), 16'h0001);
      $display("t_flash done");
   endtask : t_flash
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   initial
   begin
      {pup, wdt_ovf, wdt_mode, osc, nmi_ev, viol, unl, lck, rst_ev} = 9'h000;
      rst_n_in = 1'b0;
      freq = '0;
      repeat (10) @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      t_reset;
      t_regs;
      t_map;
      t_nmi;
      t_pup;
      t_wdt;
      t_flash;
      end_sim;
   end
   // the tests need about 115 cycles; over twenty-five times that means a hang
   initial
   begin
      repeat (3000) @(posedge clk_in);
      n_mismatch++;
      end_sim;
   end
endmodule : system_sfr_and_flash_map_tb_top
